// >>> hdl/bog_pkg.sv
package bog_pkg;

  // Clock rate and timing figures.
  localparam int unsigned CLK_HZ = 100_000_000;
  localparam int unsigned DEBOUNCE_MS = 10;
  localparam int unsigned DEBOUNCE_CYC = CLK_HZ / 1000 * DEBOUNCE_MS;
  localparam int unsigned BLINK_MS = 250;
  localparam int unsigned BLINK_CYC = CLK_HZ / 1000 * BLINK_MS;

  // Conditioned input bit positions.
  localparam int unsigned NUM_IN = 7;
  localparam int unsigned IN_SW_ONE = 0;
  localparam int unsigned IN_SW_TWO = 1;
  localparam int unsigned IN_SW_THREE = 2;
  localparam int unsigned IN_SW_FOUR = 3;
  localparam int unsigned IN_INHIBIT = 4;
  localparam int unsigned IN_SECURE = 5;
  localparam int unsigned IN_POWER = 6;

  // Widths and menu sizes.
  localparam int unsigned QTY_W = 32;
  localparam int unsigned CODE_W = 16;
  localparam int unsigned NUM_SUB = 4;
  localparam logic [1:0] SUB_INFO = 2'h3;
  localparam logic [1:0] OPR_CONFIGURE = 2'h3;
  localparam logic [1:0] LAST_DIGIT = 2'h3;
  localparam logic [3:0] BCD_NINE = 4'h9;

  // Output signal selection codes.
  localparam logic [2:0] SEL_UNUSED = 3'h0;
  localparam logic [2:0] SEL_CONTROL2 = 3'h1;
  localparam logic [2:0] SEL_CONTROL3 = 3'h2;
  localparam logic [2:0] SEL_FLOW_ALARM = 3'h3;
  localparam logic [2:0] SEL_RESET_STAT = 3'h4;
  localparam logic [2:0] SEL_BATCH_STAT = 3'h5;
  localparam logic [2:0] SEL_PULSE_OUT = 3'h6;

  // Batch sequence states.
  typedef enum logic [3:0] {
    BS_READY = 4'h1,
    BS_RUNNING = 4'h2,
    BS_PAUSED = 4'h4,
    BS_COMPLETE = 4'h8
  } bog_batch_type;

  // Menu states.
  typedef enum logic [6:0] {
    MS_OPERATE = 7'h01,
    MS_OPR_CODE = 7'h02,
    MS_OPR_MENU = 7'h04,
    MS_CFG_CODE = 7'h08,
    MS_MAIN = 7'h10,
    MS_SUB = 7'h20,
    MS_FUNC = 7'h40
  } bog_menu_type;

endpackage

// >>> hdl/bog_sw_if.sv
`timescale 1ns/100ps
`default_nettype none
interface bog_sw_if #(parameter int unsigned N = 7);
  logic [N-1:0] level;
  logic [N-1:0] press;

  // The conditioner drives, the controller reads.
  modport producer (output level, output press);
  modport consumer (input level, input press);
endinterface
`default_nettype wire

// >>> hdl/bog_debounce.sv
`timescale 1ns/100ps
`default_nettype none
module bog_debounce #(
  parameter int unsigned N = 7,
  parameter int unsigned CYC = 1_000_000
) (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_i,
  // Raw pins.
  input wire logic [N-1:0] raw_i,
  // Conditioned levels and press pulses.
  bog_sw_if.producer sw
);
  localparam int unsigned CW = $clog2(CYC + 1);
  localparam logic [CW-1:0] CNT_LAST = CW'(CYC - 1);

  logic [N-1:0] s1_q;
  logic [N-1:0] s2_q;
  logic [N-1:0] s3_q;
  logic [N-1:0] level_q;
  logic [N-1:0] press_q;
  logic [CW-1:0] cnt_q [N];

  // Three-stage synchroniser; only the second stage reads the first.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
    end
    else
    begin
      s1_q <= raw_i;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // A new level is taken only after it has stood agreed for the whole window.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      level_q <= '0;
      press_q <= '0;
      for (int i = 0; i < N; i++)
        cnt_q[i] <= '0;
    end
    else
    begin
      for (int i = 0; i < N; i++)
      begin
        press_q[i] <= 1'b0;
        if ((s2_q[i] != s3_q[i]) || (s3_q[i] == level_q[i]))
          cnt_q[i] <= '0;
        else if (cnt_q[i] == CNT_LAST)
        begin
          cnt_q[i] <= '0;
          level_q[i] <= s3_q[i];
          press_q[i] <= s3_q[i];
        end
        else
          cnt_q[i] <= cnt_q[i] + 1'b1;
      end
    end
  end

  assign sw.level = level_q;
  assign sw.press = press_q;
endmodule
`default_nettype wire

// >>> hdl/bog_batch_gate.sv
`timescale 1ns/100ps
`default_nettype none
module bog_batch_gate
  import bog_pkg::*;
#(
  parameter int unsigned DEBOUNCE = DEBOUNCE_CYC,
  parameter int unsigned BLINK = BLINK_CYC
) (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_i,
  // External switches and links.
  input wire logic ext_switch_one_i,
  input wire logic ext_switch_two_i,
  input wire logic ext_switch_three_i,
  input wire logic ext_switch_four_i,
  input wire logic inhibit_link_i,
  input wire logic security_link_i,
  input wire logic power_ok_i,
  // Flow front end, same clock.
  input wire logic flow_pulse_i,
  input wire logic [QTY_W-1:0] batch_size_i,
  input wire logic flow_alarm_i,
  input wire logic pulse_out_i,
  // Configuration.
  input wire logic cfg_code_en_i,
  input wire logic [CODE_W-1:0] cfg_code_i,
  input wire logic opr_code_en_i,
  input wire logic [CODE_W-1:0] opr_code_i,
  input wire logic opr_cfg_en_i,
  input wire logic option_fitted_i,
  input wire logic [2:0] out2_sel_i,
  input wire logic [2:0] out3_sel_i,
  input wire logic [2:0] out4_sel_i,
  input wire logic [2:0] out5_sel_i,
  input wire logic [2:0] out6_sel_i,
  input wire logic [3:0] item_count_i,
  input wire logic func_is_var_i,
  // Switch outputs.
  output logic control1_o,
  output logic out2_o,
  output logic out3_o,
  output logic out4_o,
  output logic out5_o,
  output logic out6_o,
  // Batch status.
  output logic [3:0] batch_state_o,
  output logic [QTY_W-1:0] batch_qty_o,
  output logic [QTY_W-1:0] grand_total_o,
  // Menu status.
  output logic [6:0] menu_state_o,
  output logic configuring_o,
  output logic [1:0] sub_o,
  output logic [3:0] highlight_o,
  output logic [CODE_W-1:0] edit_value_o,
  output logic [1:0] digit_pos_o,
  output logic highlight_blink_o,
  output logic highlight_on_o,
  output logic store_o,
  output logic access_denied_o
);
  localparam int unsigned BW = $clog2(BLINK + 1);
  localparam logic [BW-1:0] BLINK_LAST = BW'(BLINK - 1);

  bog_sw_if #(.N(NUM_IN)) sw_bus ();

  bog_batch_type batch_q;
  bog_menu_type menu_q;
  logic [QTY_W-1:0] qty_q;
  logic [QTY_W-1:0] total_q;
  logic [1:0] sub_q;
  logic [3:0] hl_q;
  logic [CODE_W-1:0] edit_q;
  logic [1:0] digit_q;
  logic store_q;
  logic denied_q;
  logic [BW-1:0] blink_cnt_q;
  logic blink_q;
  logic [6:0] ctl_q;

  // Returns a four-digit value with one digit stepped up or down modulo ten.
  function automatic logic [CODE_W-1:0] bcd_step(input logic [CODE_W-1:0] v,
                                                 input logic [1:0] pos,
                                                 input logic up);
    logic [CODE_W-1:0] r;
    logic [3:0] d;
    r = v;
    d = v[pos*4 +: 4];
    if (up)
      d = (d >= BCD_NINE) ? 4'h0 : d + 4'h1;
    else
      d = (d == 4'h0) ? BCD_NINE : d - 4'h1;
    r[pos*4 +: 4] = d;
    return r;
  endfunction

  // Picks one of the six selectable signals for an output.
  function automatic logic pick(input logic [2:0] sel, input logic [6:0] src);
    return (sel == SEL_UNUSED) ? 1'b0 : src[sel];
  endfunction

  // Switches, links and the supply monitor share one conditioner.
  bog_debounce #(.N(NUM_IN), .CYC(DEBOUNCE)) u_cond (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .raw_i({power_ok_i, security_link_i, inhibit_link_i, ext_switch_four_i,
            ext_switch_three_i, ext_switch_two_i, ext_switch_one_i}),
    .sw(sw_bus.producer)
  );

  logic operating;
  logic k_start, k_stop, k_reset, k_menu, k_combo;
  logic k_down, k_up, k_next, k_enter;
  logic inhibit, secure, power_ok, cfg_allowed;

  // The same switches mean different keys outside and inside the menus.
  assign operating = (menu_q == MS_OPERATE);
  assign k_start = operating & sw_bus.press[IN_SW_ONE];
  assign k_stop = operating & sw_bus.press[IN_SW_TWO];
  assign k_reset = operating & sw_bus.press[IN_SW_THREE] & ~sw_bus.level[IN_SW_FOUR];
  assign k_combo = operating & ((sw_bus.press[IN_SW_THREE] & sw_bus.level[IN_SW_FOUR]) |
                   (sw_bus.press[IN_SW_FOUR] & sw_bus.level[IN_SW_THREE]));
  assign k_menu = operating & sw_bus.press[IN_SW_FOUR] & ~sw_bus.level[IN_SW_THREE];
  assign k_down = ~operating & sw_bus.press[IN_SW_ONE];
  assign k_up = ~operating & sw_bus.press[IN_SW_TWO];
  assign k_next = ~operating & sw_bus.press[IN_SW_THREE];
  assign k_enter = ~operating & sw_bus.press[IN_SW_FOUR];
  assign inhibit = sw_bus.level[IN_INHIBIT];
  assign secure = sw_bus.level[IN_SECURE];
  assign power_ok = sw_bus.level[IN_POWER];
  // Entry is only from ready, never while running or paused.
  assign cfg_allowed = secure & (batch_q == BS_READY);

  // Batch sequence; the inhibit link plays no part here so outputs never move with it.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      batch_q <= BS_READY;
    else
    begin
      case (batch_q)
        BS_READY:
          if (k_start)
            batch_q <= BS_RUNNING;
        BS_RUNNING:
          if (k_stop)
            batch_q <= BS_PAUSED;
          else if (qty_q >= batch_size_i)
            batch_q <= BS_COMPLETE;
        BS_PAUSED:
          if (k_start)
            batch_q <= BS_RUNNING;
          else if (k_reset)
            batch_q <= BS_READY;
        BS_COMPLETE:
          if (k_reset)
            batch_q <= BS_READY;
        default:
          batch_q <= BS_READY;
      endcase
    end
  end

  // Flow is counted while running or paused, unless the inhibit link is made.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      qty_q <= '0;
      total_q <= '0;
    end
    else if (batch_q == BS_READY)
      qty_q <= '0;
    else if (flow_pulse_i && !inhibit && (batch_q != BS_COMPLETE))
    begin
      qty_q <= qty_q + 1'b1;
      total_q <= total_q + 1'b1;
    end
  end

  // Menu walk; a denied entry falls back to the operating screen.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      menu_q <= MS_OPERATE;
      sub_q <= '0;
      hl_q <= '0;
      edit_q <= '0;
      digit_q <= '0;
      store_q <= 1'b0;
      denied_q <= 1'b0;
    end
    else
    begin
      store_q <= 1'b0;
      denied_q <= 1'b0;
      case (menu_q)
        MS_OPERATE:
          if (k_combo)
          begin
            edit_q <= '0;
            digit_q <= '0;
            hl_q <= '0;
            if (!cfg_allowed)
              denied_q <= 1'b1;
            else
              menu_q <= cfg_code_en_i ? MS_CFG_CODE : MS_MAIN;
          end
          else if (k_menu)
          begin
            edit_q <= '0;
            digit_q <= '0;
            hl_q <= '0;
            menu_q <= opr_code_en_i ? MS_OPR_CODE : MS_OPR_MENU;
          end
        MS_OPR_CODE, MS_CFG_CODE:
          if (k_up || k_down)
            edit_q <= bcd_step(edit_q, digit_q, k_up);
          else if (k_next)
            digit_q <= digit_q + 2'h1;
          else if (k_enter)
          begin
            digit_q <= '0;
            if (menu_q == MS_OPR_CODE && edit_q == opr_code_i)
              menu_q <= MS_OPR_MENU;
            else if (menu_q == MS_CFG_CODE && edit_q == cfg_code_i && cfg_allowed)
              menu_q <= MS_MAIN;
            else
            begin
              denied_q <= 1'b1;
              menu_q <= MS_OPERATE;
            end
          end
        MS_OPR_MENU:
          if (k_up || k_down)
            hl_q <= {2'h0, hl_q[1:0] + (k_up ? 2'h3 : 2'h1)};
          else if (k_enter)
          begin
            edit_q <= '0;
            if (hl_q[1:0] == OPR_CONFIGURE && opr_cfg_en_i && cfg_allowed)
            begin
              hl_q <= '0;
              menu_q <= cfg_code_en_i ? MS_CFG_CODE : MS_MAIN;
            end
            else
            begin
              denied_q <= (hl_q[1:0] == OPR_CONFIGURE);
              menu_q <= MS_OPERATE;
            end
          end
        MS_MAIN:
          if (k_up || k_down)
            hl_q <= {2'h0, hl_q[1:0] + (k_up ? 2'h3 : 2'h1)};
          else if (k_next)
          begin
            sub_q <= hl_q[1:0];
            hl_q <= '0;
            menu_q <= MS_SUB;
          end
          else if (k_enter)
            menu_q <= MS_OPERATE;
        MS_SUB:
          if (k_up && item_count_i != 4'h0)
            hl_q <= (hl_q == 4'h0) ? item_count_i - 4'h1 : hl_q - 4'h1;
          else if (k_down && item_count_i != 4'h0)
            hl_q <= (hl_q + 4'h1 >= item_count_i) ? 4'h0 : hl_q + 4'h1;
          else if (k_next && sub_q != SUB_INFO)
          begin
            edit_q <= '0;
            digit_q <= '0;
            menu_q <= MS_FUNC;
          end
          else if (k_enter)
          begin
            hl_q <= {2'h0, sub_q};
            menu_q <= MS_MAIN;
          end
        MS_FUNC:
          if (func_is_var_i && (k_up || k_down))
            edit_q <= bcd_step(edit_q, digit_q, k_up);
          else if (func_is_var_i && k_next)
            digit_q <= digit_q + 2'h1;
          else if (!func_is_var_i && k_up && item_count_i != 4'h0)
            edit_q <= (edit_q == '0) ? CODE_W'(item_count_i - 4'h1) : edit_q - 1'b1;
          else if (!func_is_var_i && k_down && item_count_i != 4'h0)
            edit_q <= (edit_q + 1'b1 >= CODE_W'(item_count_i)) ? '0 : edit_q + 1'b1;
          else if (k_enter)
          begin
            store_q <= 1'b1;
            menu_q <= MS_SUB;
          end
        default:
          menu_q <= MS_OPERATE;
      endcase
    end
  end

  // Blink phase for the flashing highlight bar.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      blink_cnt_q <= '0;
      blink_q <= 1'b1;
    end
    else if (blink_cnt_q == BLINK_LAST)
    begin
      blink_cnt_q <= '0;
      blink_q <= ~blink_q;
    end
    else
      blink_cnt_q <= blink_cnt_q + 1'b1;
  end

  logic editing;
  logic [6:0] src;

  // Code and function screens flash; menu screens hold the bar steady.
  assign editing = (menu_q == MS_FUNC) || (menu_q == MS_CFG_CODE) ||
                   (menu_q == MS_OPR_CODE);
  // Selectable signal sources, indexed by selection code.
  assign src = {pulse_out_i, (batch_q == BS_RUNNING) || (batch_q == BS_PAUSED),
                batch_q == BS_READY, flow_alarm_i, batch_q == BS_RUNNING,
                batch_q == BS_RUNNING, 1'b0};

  // Switch outputs are registered and forced open without a good supply.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      ctl_q <= '0;
    else if (!power_ok)
      ctl_q <= '0;
    else
    begin
      ctl_q[0] <= (batch_q == BS_RUNNING);
      ctl_q[1] <= pick(out2_sel_i, src);
      ctl_q[2] <= pick(out3_sel_i, src);
      ctl_q[3] <= option_fitted_i & pick(out4_sel_i, src);
      ctl_q[4] <= option_fitted_i & pick(out5_sel_i, src);
      ctl_q[5] <= option_fitted_i & pick(out6_sel_i, src);
      ctl_q[6] <= editing ? blink_q : ~operating;
    end
  end

  assign control1_o = ctl_q[0];
  assign out2_o = ctl_q[1];
  assign out3_o = ctl_q[2];
  assign out4_o = ctl_q[3];
  assign out5_o = ctl_q[4];
  assign out6_o = ctl_q[5];
  assign highlight_on_o = ctl_q[6];
  assign batch_state_o = batch_q;
  assign batch_qty_o = qty_q;
  assign grand_total_o = total_q;
  assign menu_state_o = menu_q;
  assign sub_o = sub_q;
  assign highlight_o = hl_q;
  assign edit_value_o = edit_q;
  assign digit_pos_o = digit_q;
  assign store_o = store_q;
  assign access_denied_o = denied_q;

  // Status flags derived from registered menu state.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      configuring_o <= 1'b0;
      highlight_blink_o <= 1'b0;
    end
    else
    begin
      configuring_o <= ~operating;
      highlight_blink_o <= editing;
    end
  end
endmodule
`default_nettype wire

// >>> dv/bog_gate_checker.sv
`timescale 1ns/100ps
`default_nettype none
module bog_gate_checker
  import bog_pkg::*;
#(
  parameter int unsigned DEBOUNCE = 4
) (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_i,
  // Watched inputs.
  input wire logic power_ok_i,
  input wire logic inhibit_link_i,
  input wire logic security_link_i,
  input wire logic flow_pulse_i,
  input wire logic [QTY_W-1:0] batch_size_i,
  input wire logic [2:0] out2_sel_i,
  input wire logic option_fitted_i,
  // Watched outputs.
  input wire logic control1_o,
  input wire logic out2_o,
  input wire logic out3_o,
  input wire logic out4_o,
  input wire logic out5_o,
  input wire logic out6_o,
  input wire logic [3:0] batch_state_o,
  input wire logic [QTY_W-1:0] batch_qty_o,
  input wire logic [6:0] menu_state_o,
  input wire logic highlight_blink_o,
  input wire logic store_o
);
  // A raw level only counts once it has outlived synchroniser and debounce delay.
  localparam logic [7:0] THR = 8'(DEBOUNCE + 6);
  logic [7:0] pwr_lo_q;
  logic [7:0] inh_hi_q;
  logic [7:0] inh_lo_q;
  logic [7:0] sec_lo_q;
  logic any_out;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // Cycles each raw level has held, saturating at the threshold.
  always_ff @(posedge clk_i)
  begin
    pwr_lo_q <= (rst_i || power_ok_i) ? 8'h00 : pwr_lo_q + 8'(pwr_lo_q < THR);
    inh_hi_q <= (rst_i || !inhibit_link_i) ? 8'h00 : inh_hi_q + 8'(inh_hi_q < THR);
    inh_lo_q <= (rst_i || inhibit_link_i) ? 8'h00 : inh_lo_q + 8'(inh_lo_q < THR);
    sec_lo_q <= (rst_i || security_link_i) ? 8'h00 : sec_lo_q + 8'(sec_lo_q < THR);
  end

  // Any switch output closed.
  assign any_out = control1_o | out2_o | out3_o | out4_o | out5_o | out6_o;

  power_open_a: assert property (pwr_lo_q >= THR |-> !any_out)
    else $error("switch output closed without power");
  inhibit_hold_a: assert property (inh_hi_q >= THR && flow_pulse_i |=>
    $stable(batch_qty_o) || batch_state_o == BS_READY)
    else $error("quantity moved while inhibited");
  count_step_a: assert property (inh_lo_q >= THR && flow_pulse_i &&
    (batch_state_o == BS_PAUSED || batch_state_o == BS_RUNNING && batch_qty_o + 32'h1 < batch_size_i)
    |=> batch_qty_o == $past(batch_qty_o) + 32'h1 || batch_state_o == BS_READY)
    else $error("flow pulse not counted");
  run_done_a: assert property (batch_state_o == BS_RUNNING && batch_qty_o >= batch_size_i
    |=> batch_state_o == BS_COMPLETE)
    else $error("batch did not complete at target");
  control_run_a: assert property (control1_o |-> $past(batch_state_o) == BS_RUNNING)
    else $error("control closed outside a running batch");
  stop_open_a: assert property ($past(batch_state_o) == BS_RUNNING &&
    batch_state_o == BS_PAUSED |=> !control1_o)
    else $error("control still closed after pause");
  secure_gate_a: assert property (sec_lo_q >= THR &&
    menu_state_o inside {MS_OPERATE, MS_OPR_MENU} |=> !(menu_state_o inside {MS_MAIN, MS_CFG_CODE}))
    else $error("configuration opened without link");
  run_gate_a: assert property (batch_state_o == BS_RUNNING && menu_state_o == MS_OPERATE
    |=> menu_state_o != MS_MAIN && menu_state_o != MS_CFG_CODE)
    else $error("configuration opened while running");
  blink_edit_a: assert property (highlight_blink_o ==
    ($past(menu_state_o) inside {MS_FUNC, MS_CFG_CODE, MS_OPR_CODE}))
    else $error("blink does not match screen kind");
  store_up_a: assert property (store_o |-> menu_state_o == MS_SUB &&
    $past(menu_state_o) == MS_FUNC)
    else $error("store without return to sub menu");
  sel_ctl2_a: assert property (out2_sel_i == SEL_CONTROL2 &&
    $past(out2_sel_i) == SEL_CONTROL2 |-> out2_o == control1_o)
    else $error("output two does not follow control");
  opt_off_a: assert property (!option_fitted_i && !$past(option_fitted_i)
    |-> !(out4_o | out5_o | out6_o))
    else $error("optional output closed while not fitted");
endmodule

bind bog_batch_gate bog_gate_checker #(.DEBOUNCE(DEBOUNCE)) u_chk (
  .clk_i(clk_i), .rst_i(rst_i), .power_ok_i(power_ok_i), .inhibit_link_i(inhibit_link_i),
  .security_link_i(security_link_i), .flow_pulse_i(flow_pulse_i), .batch_size_i(batch_size_i),
  .out2_sel_i(out2_sel_i), .option_fitted_i(option_fitted_i), .control1_o(control1_o),
  .out2_o(out2_o), .out3_o(out3_o), .out4_o(out4_o), .out5_o(out5_o), .out6_o(out6_o),
  .batch_state_o(batch_state_o), .batch_qty_o(batch_qty_o), .menu_state_o(menu_state_o),
  .highlight_blink_o(highlight_blink_o), .store_o(store_o)
);
`default_nettype wire

// >>> dv/bog_panel_model.sv
`timescale 1ns/100ps
`default_nettype none
module bog_panel_model (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_i,
  // Key closures commanded by the bench, bit 0 for switch one.
  input wire logic [3:0] key_i,
  // Raw contacts at the pins.
  output logic [3:0] pin_o
);
  logic [3:0] last_q;
  logic [3:0] moved_q;
  logic [1:0] chat_q;

  // A real contact chatters after it moves, so a moved pin flips for a few cycles.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      last_q <= 4'h0;
      moved_q <= 4'h0;
      chat_q <= 2'h0;
    end
    else
    begin
      last_q <= key_i;
      if (key_i != last_q)
      begin
        moved_q <= key_i ^ last_q;
        chat_q <= 2'h3;
      end
      else if (chat_q != 2'h0)
        chat_q <= chat_q - 2'h1;
    end
  end

  // Each pin keeps one fixed switch role; chords are simply two keys held.
  assign pin_o = key_i ^ (moved_q & {4{chat_q[0]}});
endmodule
`default_nettype wire

// >>> dv/bog_batch_gate_bench.sv
`timescale 1ns/100ps
`default_nettype none
module bog_batch_gate_bench;
  import bog_pkg::*;
  localparam int HOLD = 16;
  localparam int LIMIT = 8000;
  // Stimulus, all but pins given values at time zero.
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [3:0] key = 4'h0;
  logic [3:0] pins;
  logic inhibit = 1'b0;
  logic secure = 1'b0;
  logic power = 1'b1;
  logic flow = 1'b0;
  logic fitted = 1'b0;
  logic cfg_en = 1'b0;
  logic opr_en = 1'b0;
  logic opr_cfg = 1'b0;
  logic [CODE_W-1:0] cfg_code = 16'h0000;
  logic [CODE_W-1:0] opr_code = 16'h0000;
  logic [QTY_W-1:0] size = 32'h5;
  logic [2:0] sel2 = SEL_CONTROL2;
  logic [2:0] sel3 = SEL_BATCH_STAT;
  logic [2:0] sel4 = SEL_CONTROL3;
  logic [3:0] items = 4'h3;
  logic is_var = 1'b0;
  // Observed outputs.
  logic c1, o2, o3, o4, o5, o6, cfgg, blink, hl_on, store, denied;
  logic [3:0] bstate, hl;
  logic [QTY_W-1:0] qty, total;
  logic [6:0] mstate;
  logic [1:0] sub, dpos;
  logic [CODE_W-1:0] edit;
  int n_fail = 0;
  int num_checks = 0;
  int n_denied = 0;
  int n_store = 0;
  int cyc = 0;

  always #5 clk_i = ~clk_i;

  bog_panel_model u_panel (.clk_i(clk_i), .rst_i(rst_i), .key_i(key), .pin_o(pins));

  bog_batch_gate #(.DEBOUNCE(4), .BLINK(8)) DUT (
    .clk_i(clk_i), .rst_i(rst_i), .ext_switch_one_i(pins[0]), .ext_switch_two_i(pins[1]),
    .ext_switch_three_i(pins[2]), .ext_switch_four_i(pins[3]), .inhibit_link_i(inhibit),
    .security_link_i(secure), .power_ok_i(power), .flow_pulse_i(flow), .batch_size_i(size),
    .flow_alarm_i(1'b0), .pulse_out_i(1'b0), .cfg_code_en_i(cfg_en), .cfg_code_i(cfg_code),
    .opr_code_en_i(opr_en), .opr_code_i(opr_code), .opr_cfg_en_i(opr_cfg),
    .option_fitted_i(fitted), .out2_sel_i(sel2), .out3_sel_i(sel3), .out4_sel_i(sel4),
    .out5_sel_i(SEL_UNUSED), .out6_sel_i(SEL_UNUSED), .item_count_i(items),
    .func_is_var_i(is_var), .control1_o(c1), .out2_o(o2), .out3_o(o3), .out4_o(o4),
    .out5_o(o5), .out6_o(o6), .batch_state_o(bstate), .batch_qty_o(qty),
    .grand_total_o(total), .menu_state_o(mstate), .configuring_o(cfgg), .sub_o(sub),
    .highlight_o(hl), .edit_value_o(edit), .digit_pos_o(dpos), .highlight_blink_o(blink),
    .highlight_on_o(hl_on), .store_o(store), .access_denied_o(denied)
  );

  // One-cycle pulses are tallied so that slow scenarios cannot miss them.
  always @(posedge clk_i)
  begin
    cyc++;
    if (denied === 1'b1) n_denied++;
    if (store === 1'b1) n_store++;
    if (cyc > LIMIT)
    begin
      n_fail++;
      stop_test();
    end
  end

  task automatic stop_test();
    $display("checks %0d, mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask

  task automatic idle(input int n);
    repeat (n) @(negedge clk_i);
  endtask

  // Held long enough to outlast chatter, synchroniser and debounce both ways.
  task automatic press(input logic [3:0] k);
    key = k;
    idle(HOLD);
    key = 4'h0;
    idle(HOLD);
  endtask

  // Next held, then enter added.
  task automatic chord();
    key = 4'h4;
    idle(HOLD);
    key = 4'hc;
    idle(HOLD);
    key = 4'h0;
    idle(HOLD);
  endtask

  task automatic pulses(input int n);
    repeat (n)
    begin
      flow = 1'b1;
      idle(1);
      flow = 1'b0;
      idle(1);
    end
    idle(4);
  endtask

  task automatic t_reset();
    chk(mstate, MS_OPERATE);
    chk(bstate, BS_READY);
    chk(c1 | o2 | o3 | o4, 1'b0);
  endtask

  task automatic t_deny();
    int d;
    d = n_denied;
    chord();
    chk(mstate, MS_OPERATE);
    chk(32'(n_denied - d), 32'h1);
  endtask

  task automatic t_batch();
    press(4'h1);
    chk(bstate, BS_RUNNING);
    chk({c1, o2, o4}, 3'h6);
    fitted = 1'b1;
    idle(4);
    chk({o4, o5, o6}, 3'h4);
    pulses(2);
    chk(qty, 32'h2);
    inhibit = 1'b1;
    idle(HOLD);
    pulses(2);
    chk(qty, 32'h2);
    chk({c1, o2, o4}, 3'h7);
    inhibit = 1'b0;
    idle(HOLD);
    press(4'h2);
    chk(bstate, BS_PAUSED);
    chk({c1, o2, o4, o3}, 4'h1);
    pulses(1);
    chk(qty, 32'h3);
    press(4'h1);
    pulses(2);
    chk(bstate, BS_COMPLETE);
    chk(c1, 1'b0);
    chk(total, 32'h5);
    press(4'h4);
    chk(bstate, BS_READY);
    chk(qty, 32'h0);
  endtask

  task automatic t_power();
    int d;
    secure = 1'b1;
    idle(HOLD);
    press(4'h1);
    d = n_denied;
    chord();
    chk(mstate, MS_OPERATE);
    chk(32'(n_denied - d), 32'h1);
    power = 1'b0;
    idle(HOLD);
    chk(c1 | o2 | o3 | o4, 1'b0);
    power = 1'b1;
    idle(HOLD);
    press(4'h2);
    press(4'h4);
    chk(bstate, BS_READY);
  endtask

  task automatic t_nav();
    int s;
    chord();
    chk(mstate, MS_MAIN);
    chk({cfgg, hl}, 5'h10);
    for (int i = 1; i <= 4; i++)
    begin
      press(4'h1);
      chk(hl, 32'(i % 4));
    end
    press(4'h2);
    chk(hl, 32'h3);
    press(4'h4);
    chk({mstate, sub}, {MS_SUB, 2'h3});
    press(4'h4);
    chk(mstate, MS_SUB);
    press(4'h8);
    chk({mstate, hl}, {MS_MAIN, 4'h3});
    press(4'h1);
    press(4'h4);
    chk({mstate, sub}, {MS_SUB, 2'h0});
    chk({hl_on, blink}, 2'h2);
    press(4'h4);
    chk(mstate, MS_FUNC);
    chk(blink, 1'b1);
    press(4'h1);
    chk(edit, 16'h0001);
    s = n_store;
    press(4'h8);
    chk(32'(n_store - s), 32'h1);
    chk(mstate, MS_SUB);
    // A variable function steps digits: up on digit zero, then down on digit one.
    is_var = 1'b1;
    press(4'h4);
    press(4'h2);
    press(4'h4);
    press(4'h1);
    chk({dpos, edit}, {2'h1, 16'h0091});
    press(4'h8);
    chk(mstate, MS_SUB);
    press(4'h8);
    chk(mstate, MS_MAIN);
    press(4'h8);
    chk(mstate, MS_OPERATE);
  endtask

  task automatic t_code();
    int d;
    cfg_en = 1'b1;
    cfg_code = 16'h0019;
    d = n_denied;
    chord();
    chk(mstate, MS_CFG_CODE);
    press(4'h8);
    chk(mstate, MS_OPERATE);
    // Digit zero wraps down to nine, digit one steps up to one.
    chord();
    press(4'h1);
    press(4'h4);
    press(4'h2);
    chk({dpos, edit}, {2'h1, 16'h0019});
    press(4'h8);
    chk(mstate, MS_MAIN);
    press(4'h8);
    opr_en = 1'b1;
    opr_code = 16'h0003;
    press(4'h8);
    chk(mstate, MS_OPR_CODE);
    press(4'h8);
    chk(mstate, MS_OPERATE);
    chk(32'(n_denied - d), 32'h2);
    opr_code = 16'h0000;
    press(4'h8);
    press(4'h8);
    chk(mstate, MS_OPR_MENU);
    press(4'h8);
    chk(mstate, MS_OPERATE);
    // Configure item of the operator menu leads on to the configuration code.
    opr_cfg = 1'b1;
    press(4'h8);
    press(4'h8);
    press(4'h2);
    press(4'h8);
    chk(mstate, MS_CFG_CODE);
    press(4'h8);
    chk(mstate, MS_OPERATE);
  endtask

  // Reset for two cycles, then the scenarios in turn.
  initial
  begin
    repeat (2) @(negedge clk_i);
    rst_i = 1'b0;
    idle(2);
    t_reset();
    t_deny();
    t_batch();
    t_power();
    t_nav();
    t_code();
    stop_test();
  end
endmodule
`default_nettype wire
